// *** verilog/hlt_pkg.sv ***
// Package with mode codes, widths and reset values of the hardware-limit timer.
package hlt_pkg;
  localparam int          COUNT_W        = 8;
  localparam logic [4:0]  MODE_SW_GATE   = 5'h00;
  localparam logic [4:0]  MODE_HW_GATE_H = 5'h01;
  localparam logic [4:0]  MODE_HW_GATE_L = 5'h02;
  localparam logic [4:0]  MODE_ANY_RST   = 5'h03;
  localparam logic [4:0]  MODE_RISE_RST  = 5'h04;
  localparam logic [4:0]  MODE_FALL_RST  = 5'h05;
  localparam logic [4:0]  MODE_LOW_RST   = 5'h06;
  localparam logic [4:0]  MODE_HIGH_RST  = 5'h07;
  localparam logic [4:0]  MODE_OS_SW     = 5'h08;
  localparam logic [4:0]  MODE_OS_RISE   = 5'h09;
  localparam logic [4:0]  MODE_OS_FALL   = 5'h0a;
  localparam logic [4:0]  MODE_OS_ANY    = 5'h0b;
  localparam logic [4:0]  MODE_OS_RR     = 5'h0c;
  localparam logic [4:0]  MODE_OS_FF     = 5'h0d;
  localparam logic [4:0]  MODE_OS_RL     = 5'h0e;
  localparam logic [4:0]  MODE_OS_FH     = 5'h0f;
  localparam logic [4:0]  MODE_MS_RISE   = 5'h11;
  localparam logic [4:0]  MODE_MS_FALL   = 5'h12;
  localparam logic [4:0]  MODE_MS_ANY    = 5'h13;
  localparam logic [4:0]  MODE_LV_HL     = 5'h16;
  localparam logic [4:0]  MODE_LV_LH     = 5'h17;
  localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
endpackage : hlt_pkg

// *** verilog/hlt_ctl_if.sv ***
// Interface carrying decoded timer controls from the mode decoder to the counter.
`timescale 1ns/1ps
`default_nettype none
interface hlt_ctl_if;
  logic gate;      // Counting allowed this cycle.
  logic hw_reset;  // Clear the counter this cycle.
  logic start;     // Qualifying start event.
  logic one_shot;  // Match clears run-enable.
  logic mono;      // Match stops, keeps run-enable.
  logic edge_arm;  // Mode needs an edge to start.
  modport dec (output gate, hw_reset, start, one_shot, mono, edge_arm);
  modport cnt (input gate, hw_reset, start, one_shot, mono, edge_arm);
endinterface : hlt_ctl_if
`default_nettype wire

// *** verilog/hlt_mode_decode.sv ***
// Combinational decoder from mode code and signal edges to timer controls.
`timescale 1ns/1ps
`default_nettype none
module hlt_mode_decode
  import hlt_pkg::*;
(
  input  wire logic [4:0] mode_in,   // Mode code.
  input  wire logic       ers_in,    // External signal level.
  input  wire logic       rise_in,   // Rising edge seen.
  input  wire logic       fall_in,   // Falling edge seen.
  hlt_ctl_if.dec          ctl        // Decoded controls.
);
  always_comb begin
    ctl.gate     = 1'b1;
    ctl.hw_reset = 1'b0;
    ctl.start    = 1'b0;
    ctl.one_shot = 1'b0;
    ctl.mono     = 1'b0;
    ctl.edge_arm = 1'b0;
    unique case (mode_in)
      MODE_SW_GATE:   ctl.gate = 1'b1; // RULE1
      MODE_HW_GATE_H: ctl.gate = ers_in; // RULE1
      MODE_HW_GATE_L: ctl.gate = !ers_in; // RULE1
      MODE_ANY_RST:   ctl.hw_reset = rise_in | fall_in; // RULE2
      MODE_RISE_RST:  ctl.hw_reset = rise_in; // RULE3
      MODE_FALL_RST:  ctl.hw_reset = fall_in; // RULE3
      MODE_LOW_RST:   ctl.hw_reset = !ers_in; // RULE4
      MODE_HIGH_RST:  ctl.hw_reset = ers_in; // RULE4
      MODE_OS_SW: begin
        ctl.one_shot = 1'b1; // RULE5
        ctl.start    = 1'b1;
      end
      MODE_OS_RISE, MODE_OS_FALL, MODE_OS_ANY: begin
        ctl.one_shot = 1'b1; // RULE6
        ctl.edge_arm = 1'b1;
        ctl.start    = (mode_in == MODE_OS_RISE) ? rise_in :
                       (mode_in == MODE_OS_FALL) ? fall_in : (rise_in | fall_in);
      end
      MODE_OS_RR, MODE_OS_FF: begin
        ctl.one_shot = 1'b1;
        ctl.edge_arm = 1'b1;
        ctl.start    = (mode_in == MODE_OS_RR) ? rise_in : fall_in; // RULE7
        ctl.hw_reset = ctl.start; // RULE7
      end
      MODE_OS_RL, MODE_OS_FH: begin
        ctl.one_shot = 1'b1;
        ctl.edge_arm = 1'b1;
        ctl.start    = (mode_in == MODE_OS_RL) ? rise_in : fall_in; // RULE8
        ctl.hw_reset = (mode_in == MODE_OS_RL) ? !ers_in : ers_in; // RULE8
      end
      MODE_MS_RISE, MODE_MS_FALL, MODE_MS_ANY: begin
        ctl.mono     = 1'b1; // RULE10
        ctl.edge_arm = 1'b1;
        ctl.start    = (mode_in == MODE_MS_RISE) ? rise_in :
                       (mode_in == MODE_MS_FALL) ? fall_in : (rise_in | fall_in);
      end
      MODE_LV_HL, MODE_LV_LH: begin
        ctl.one_shot = 1'b1;
        ctl.start    = (mode_in == MODE_LV_HL) ? ers_in : !ers_in; // RULE9
        ctl.hw_reset = !ctl.start; // RULE9
      end
      default: ctl.gate = 1'b0; // RULE11
    endcase
  end
endmodule : hlt_mode_decode
`default_nettype wire

// *** verilog/hlt_timer.sv ***
// Top of the hardware-limit timer: mode control, counter and run-enable.
// Behaviour
// RULE1: Code 00000 counts while run-enable is set, 00001 also needs the signal high, 00010 needs it low.
// RULE2: Code 00011 resets the running count on either edge of the external signal.
// RULE3: Code 00100 resets on a rising edge and 00101 on a falling edge; run-enable low stops counting.
// RULE4: Code 00110 holds the count in reset while the signal is low and 00111 while it is high.
// RULE5: Code 01000 runs one counting cycle started by setting run-enable alone.
// RULE6: Codes 01001, 01010, 01011 start a one-shot on rising, falling or any edge with run-enable set.
// RULE7: Codes 01100 and 01101 use a rising or falling edge both to start and to reset the count.
// RULE8: Codes 01110 and 01111 start on a rising or falling edge and reset on a low or high level.
// RULE9: Codes 10110 and 10111 start on a high or low level and reset on the opposite level.
// RULE10: Codes 10001, 10010, 10011 run monostable on rising, falling or any edge with no hardware reset.
// RULE11: Software must not program reserved codes; the timer simply holds still on them.
// RULE12: In edge-started modes, after run-enable is cleared and set, a new edge is needed to restart.
// RULE13: In one-shot modes the clock after a period match clears run-enable and stops the count at zero.
// RULE14: In monostable modes the clock after a period match stops the count at zero but keeps run-enable.
`timescale 1ns/1ps
`default_nettype none
module hlt_timer
  import hlt_pkg::*;
(
  input  wire logic               clock_in,                 // 10 MHz clock.
  input  wire logic               nrst_in,                  // Synchronous reset, active low.
  input  wire logic               ce_in,                    // Clock enable, freezes state when low.
  input  wire logic [4:0]         mode_in,                  // Mode code.
  input  wire logic               run_set_in,               // Software sets run-enable (pulse).
  input  wire logic               run_clr_in,               // Software clears run-enable (pulse).
  input  wire logic               external_reset_signal_in, // External gate/reset signal.
  input  wire logic [COUNT_W-1:0] period_value_in,          // Period compare value.
  output logic      [COUNT_W-1:0] timer_count_out,          // Counter value.
  output logic                    run_enable_out,           // Run-enable bit.
  output logic                    running_out,              // Counter is active.
  output logic                    match_out                 // Period match pulse.
);
  hlt_ctl_if ctl ();

  logic               ers_r, ers_nxt;
  logic               run_r, run_nxt;
  logic               act_r, act_nxt;
  logic               done_r, done_nxt;
  logic               match_r, match_nxt;
  logic [COUNT_W-1:0] cnt_r, cnt_nxt;
  logic               rise, fall, at_period;

  assign rise = external_reset_signal_in & !ers_r;
  assign fall = !external_reset_signal_in & ers_r;
  assign at_period = (cnt_r == period_value_in);

  hlt_mode_decode u_dec (
    .mode_in (mode_in),
    .ers_in  (external_reset_signal_in),
    .rise_in (rise),
    .fall_in (fall),
    .ctl     (ctl)
  );

  // ****************************************************************
  // Next-state logic for run-enable, activity and the counter.
  // ****************************************************************
  always_comb begin
    ers_nxt   = external_reset_signal_in;
    run_nxt   = run_r;
    act_nxt   = act_r;
    done_nxt  = done_r;
    cnt_nxt   = cnt_r;
    match_nxt = 1'b0;
    if (ctl.one_shot || ctl.mono) begin
      // A match stops the count at zero on the next clock.
      if (act_r && at_period) begin
        match_nxt = 1'b1;
        cnt_nxt   = COUNT_RST; // RULE13 RULE14
        act_nxt   = 1'b0;
        done_nxt  = 1'b1;
        if (ctl.one_shot) begin
          run_nxt = 1'b0; // RULE13
        end
      end else if (!run_r) begin
        act_nxt = 1'b0;
        // A hardware reset level or edge clears the count even while run-enable is low.
        if (ctl.hw_reset) begin
          cnt_nxt = COUNT_RST; // RULE8 RULE9
        end
      end else if (ctl.hw_reset) begin
        cnt_nxt = COUNT_RST; // RULE7 RULE8 RULE9
        if (ctl.start) begin
          act_nxt = 1'b1;
        end else if (!ctl.edge_arm) begin
          act_nxt = 1'b0;
        end
      end else if (!act_r && ctl.start && !(ctl.mono && done_r && !ctl.edge_arm)) begin
        act_nxt = !(mode_in == MODE_OS_SW && done_r); // RULE5 RULE6 RULE10 RULE12
      end else if (act_r) begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end else begin
      act_nxt = run_r && ctl.gate && !ctl.hw_reset;
      if (ctl.hw_reset) begin
        cnt_nxt = COUNT_RST; // RULE2 RULE3 RULE4
      end else if (run_r && ctl.gate) begin
        if (at_period) begin
          cnt_nxt   = COUNT_RST;
          match_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1; // RULE1
        end
      end
    end
    // Software writes win over the hardware clear of run-enable.
    if (run_clr_in) begin
      run_nxt = 1'b0;
      act_nxt = 1'b0; // RULE12
    end
    if (run_set_in) begin
      run_nxt  = 1'b1;
      done_nxt = 1'b0;
    end
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      ers_r   <= 1'b0;
      run_r   <= 1'b0;
      act_r   <= 1'b0;
      done_r  <= 1'b0;
      match_r <= 1'b0;
      cnt_r   <= COUNT_RST;
    end else if (ce_in) begin
      ers_r   <= ers_nxt;
      run_r   <= run_nxt;
      act_r   <= act_nxt;
      done_r  <= done_nxt;
      match_r <= match_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign timer_count_out = cnt_r;
  assign run_enable_out  = run_r;
  assign running_out     = act_r;
  assign match_out       = match_r;
endmodule : hlt_timer
`default_nettype wire

// *** verification/hlt_ers_source.sv ***
// Model of the source that drives the external gate and reset signal.
`timescale 1ns/1ps
`default_nettype none
module hlt_ers_source (
  input  wire logic clock_in, // Timer clock.
  input  wire logic hold_in,  // Hold the requested level.
  input  wire logic level_in, // Requested level.
  input  wire logic rnd_in,   // Random level when not held.
  output logic      ext_out   // External signal.
);
  // The signal moves just after a clock edge, as a synchronised source would.
  initial ext_out = 1'b0;
  always @(posedge clock_in) ext_out <= #1 (hold_in ? level_in : rnd_in);
endmodule : hlt_ers_source
`default_nettype wire

// *** verification/hlt_timer_properties.sv ***
// Port checks of the hardware-limit timer.
`timescale 1ns/1ps
`default_nettype none
module hlt_timer_properties
  import hlt_pkg::*;
(
  input wire logic               clock_in,                 // Clock.
  input wire logic               nrst_in,                  // Reset.
  input wire logic               ce_in,                    // Enable.
  input wire logic [4:0]         mode_in,                  // Mode.
  input wire logic               run_set_in,               // Set.
  input wire logic               run_clr_in,               // Clear.
  input wire logic               external_reset_signal_in, // Signal.
  input wire logic [COUNT_W-1:0] period_value_in,          // Period.
  input wire logic [COUNT_W-1:0] timer_count_out,          // Count.
  input wire logic               run_enable_out,           // Run.
  input wire logic               match_out                 // Match.
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  logic ext, prev_r, prev_nxt, lvl, edg, os, ms;
  assign ext = external_reset_signal_in;
  always_comb prev_nxt = ce_in ? ext : prev_r;
  always_ff @(posedge clock_in) prev_r <= nrst_in ? prev_nxt : 1'b0;
  assign lvl = ext ? (mode_in == MODE_HIGH_RST || mode_in == MODE_OS_FH || mode_in == MODE_LV_LH)
                   : (mode_in == MODE_LOW_RST || mode_in == MODE_OS_RL || mode_in == MODE_LV_HL);
  assign edg = (mode_in == MODE_ANY_RST && ext != prev_r) || (mode_in == MODE_RISE_RST && ext && !prev_r)
             || (mode_in == MODE_FALL_RST && !ext && prev_r);
  assign os = mode_in[4:3] == 2'h1 || mode_in == MODE_LV_HL || mode_in == MODE_LV_LH;
  assign ms = mode_in[4:2] == 3'h4 && mode_in[1:0] != 2'h0;
  run_set_a: assert property (ce_in && run_set_in && timer_count_out != period_value_in |=> run_enable_out)
    else $error("set");
  run_clr_a: assert property (ce_in && run_clr_in && !run_set_in |=> !run_enable_out)
    else $error("clear");
  hw_gate_a: assert property (ce_in && (mode_in == MODE_HW_GATE_H && !ext || mode_in == MODE_HW_GATE_L && ext)
    |=> $stable(timer_count_out)) else $error("gate");
  edge_reset_a: assert property (ce_in && $past(ce_in) && edg && run_enable_out && !run_clr_in
    |=> timer_count_out == COUNT_RST) else $error("edge");
  level_reset_a: assert property (ce_in && lvl |=> timer_count_out == COUNT_RST)
    else $error("level");
  reserved_hold_a: assert property (ce_in && (mode_in == 5'h10 || mode_in == 5'h14 || mode_in == 5'h15
    || mode_in[4:3] == 2'h3) |=> $stable(timer_count_out)) else $error("reserved");
  oneshot_done_a: assert property (match_out && os && $stable(mode_in) && !$past(run_set_in)
    |-> !run_enable_out && timer_count_out == COUNT_RST) else $error("oneshot");
  mono_done_a: assert property (match_out && ms && $stable(mode_in) && !$past(run_clr_in)
    |-> run_enable_out && timer_count_out == COUNT_RST) else $error("mono");
endmodule : hlt_timer_properties
bind hlt_timer hlt_timer_properties chk (.clock_in, .nrst_in, .ce_in, .mode_in, .run_set_in, .run_clr_in,
  .external_reset_signal_in, .period_value_in, .timer_count_out, .run_enable_out, .match_out);
`default_nettype wire

// *** verification/hlt_timer_test.sv ***
// Self-checking bench of the hardware-limit timer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end
module hlt_timer_test;
  import hlt_pkg::*;
  logic               clock_in = 1'b0;
  logic               nrst_in = 1'b0;
  logic               ce_in = 1'b1;
  logic [4:0]         mode_in = 5'h00;
  logic               run_set_in = 1'b0;
  logic               run_clr_in = 1'b0;
  logic               hold = 1'b1;
  logic               level = 1'b0;
  logic [15:0]        rnd = 16'h8b28;
  logic [COUNT_W-1:0] period_value_in = 8'h03;
  logic               external_reset_signal_in;
  logic [COUNT_W-1:0] timer_count_out;
  logic               run_enable_out;
  logic               match_out;
  int                 err_total = 0;
  int                 samples_checked = 0;
  int                 p;
  logic [4:0]         modes [23] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
    5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h16, 5'h17, 5'h10, 5'h18};
  always #50 clock_in = ~clock_in;
  hlt_ers_source ers (.clock_in, .hold_in(hold), .level_in(level), .rnd_in(rnd[0]), .ext_out(external_reset_signal_in));
  hlt_timer dut (.clock_in, .nrst_in, .ce_in, .mode_in, .run_set_in, .run_clr_in, .external_reset_signal_in,
                 .period_value_in, .timer_count_out, .run_enable_out, .running_out(), .match_out);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [COUNT_W-1:0] exp_count(input int k, input int per, input bit one);
    if (one) return (k > per + 1) ? COUNT_RST : COUNT_W'(k - 1);
    return COUNT_W'(k % (per + 1));
  endfunction : exp_count
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
    rnd = lfsr(rnd);
  endtask : step
  task automatic pulse(input logic s, input logic c);
    run_set_in = s;
    run_clr_in = c;
    step(1);
    run_set_in = 1'b0;
    run_clr_in = 1'b0;
  endtask : pulse
  task automatic restart(input logic [4:0] m);
    {nrst_in, run_set_in, run_clr_in, hold, level, ce_in} = 6'h05;
    mode_in = m;
    p = 2 + int'(rnd[2:0]);
    period_value_in = COUNT_W'(p);
    step(3);
    nrst_in = 1'b1;
  endtask : restart
  initial begin
    for (int i = 0; i < 2; i++) begin
      restart(i ? MODE_OS_SW : MODE_SW_GATE);
      pulse(1'b1, 1'b0);
      for (int k = 1; k <= 2 * p + 3; k++) begin
        step(1);
        `CHK("count", exp_count(k, p, i), timer_count_out)
      end
      `CHK("run_enable", 1'(i == 0), run_enable_out)
    end
    for (int i = 0; i < 2; i++) begin
      restart(i ? MODE_MS_RISE : MODE_OS_RISE);
      pulse(1'b1, 1'b0);
      step(2);
      level = 1'b1;
      for (int t = 0; t < 40 && match_out !== 1'b1; t++) step(1);
      if (match_out !== 1'b1) begin
        err_total++;
        stop_test();
      end
      `CHK("run_enable", 1'(i == 1), run_enable_out)
      pulse(1'b0, 1'b1);
      pulse(1'b1, 1'b0);
      step(4);
      `CHK("count", COUNT_RST, timer_count_out)
    end
    foreach (modes[j]) begin
      restart(modes[j]);
      pulse(1'b1, 1'b0);
      hold = 1'b0;
      repeat (60) begin
        step(1);
        ce_in = rnd[3:1] != 3'h0;
        run_set_in = rnd[7:4] == 4'h0;
        run_clr_in = rnd[11:8] == 4'h0;
      end
      if (j > 20) `CHK("count", COUNT_RST, timer_count_out)
    end
    stop_test();
  end
endmodule : hlt_timer_test
`default_nettype wire
